/* hdl/vpw_link_defines.vh */
// constants for the vpw link control register block
`ifndef VPW_LINK_DEFINES_VH
`define VPW_LINK_DEFINES_VH
`define ADDR_CTRL_ONE     4'h0
`define ADDR_CTRL_TWO     4'h4
`define ADDR_STATUS       4'h8
`define ADDR_VECTOR       4'hc
`define C1_FREQ_BIT       6
`define C1_RATE_HI_BIT    5
`define C1_RATE_LO_BIT    4
`define C1_IRQ_EN_BIT     1
`define C1_WAIT_STOP_BIT  0
`define C2_ANALOG_LOOPBACK_BIT      7
`define C2_DIGITAL_LOOPBACK_BIT      6
`define C2_FAST_RX_BIT    5
`define C2_NBF_BIT        4
`define C2_EOD_BIT        3
`define C2_SINGLE_BIT     2
`define C2_MCRC_BIT       1
`define C2_MNOCRC_BIT     0
`define CTRL_ONE_RESET    8'h00
`define CTRL_TWO_RESET    8'hc0
`define VECTOR_BREAK      16'h001c
`define VECTOR_TX_EMPTY   16'h0020
`define VECTOR_IDLE       16'h0000
`define EOF_TIME_US       280
`define IFS_TIME_US       300
`define CLK_MHZ           40
`define EOF_CYCLES        (`EOF_TIME_US * `CLK_MHZ)
`define IFS_CYCLES        (`IFS_TIME_US * `CLK_MHZ)
`define IDLE_CNT_W        14
`define EOF_COUNT         14'h2bc0
`define IFS_COUNT         14'h2ee0
`endif

/* hdl/vpw_link_control_regs.v */
// control and response logic of the vpw serial link controller
//
// Summary of operation
// - frequency bit selects 1.048576 MHz binary or 1 MHz integer timebase.
// - rate bits divide system clock by 1, 2, 4 or 8.
// - rate bits accept one write per reset, then become read-only.
// - interrupt enable gates run-mode requests only, not wake-up requests.
// - interrupt request stays asserted until every pending source is cleared.
// - pending interrupts may be discarded when enable is cleared.
// - wait clock bit stops internal clocks during cpu wait mode.
// - analog loopback routes drive-stage input to receiver, bus undriven; here the bit only starts the idle wait, the pin stays driven.
// - after analog loopback clears, wait eof idle to receive, ifs to send.
// - digital loopback connects receive input to transmit output.
// - after digital loopback clears, require eof idle rx, ifs idle tx.
// - fast receive bit selects receive-only 41.6 kbps, else 10.4 kbps.
// - received break clears fast receive and loads vector 001c hex.
// - normalization format bit picks nb level for crc or non-crc responses.
// - end of data appends crc after current byte and any shadow byte.
// - setting end of data clears transmit-empty flag at once.
// - end of data auto-clears on first crc bit, valid eod, or error.
// - several response bits: act on highest priority, read back as written.
// - losing single-byte responder keeps sending its id until its own byte is seen.
// - responder sends one active normalization bit before its id byte.
//
// Our own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "vpw_link_defines.vh"

module vpw_link_control_regs (
    input  wire        clk_i,
    input  wire        rst_i,
    // classic wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // cpu and mode context
    input  wire        cpu_wait_i,
    input  wire        wake_req_i,
    input  wire        irq_src_i,
    // link core events, same clock
    input  wire        break_rx_i,
    input  wire        crc_bit_start_i,
    input  wire        eod_rx_valid_i,
    input  wire        bus_error_i,
    input  wire        tx_empty_set_i,
    input  wire        shadow_full_i,
    input  wire        ifr_lost_i,
    input  wire        own_byte_seen_i,
    input  wire        core_tx_i,
    // transceiver pins
    input  wire        digital_rx_in_i,
    output reg         digital_tx_out_o,
    output reg         link_rx_o,
    // link core control
    output reg         link_timebase_o,
    output reg         timebase_binary_o,
    output reg         core_clk_en_o,
    output reg         irq_o,
    output reg         fast_rx_mode_o,
    output reg         rx_allow_o,
    output reg         tx_allow_o,
    output reg         norm_bit_crc_o,
    output reg         norm_bit_nocrc_o,
    output reg         crc_after_shadow_o,
    output reg         send_single_o,
    output reg         send_multi_crc_o,
    output reg         send_multi_nocrc_o,
    output reg         resend_id_o,
    output reg         send_norm_bit_o
);

    reg  [7:0]  ctrl_one_reg;
    reg         rate_locked_reg;
    reg  [7:0]  ctrl_two_reg;
    reg  [15:0] vector_reg;
    reg         tx_empty_reg;
    reg         irq_pend_reg;
    reg  [2:0]  div_cnt_reg;
    reg  [13:0] idle_cnt_reg;
    reg         idle_wait_reg;
    reg         rx_meta_reg;
    reg         rx_sync_reg;
    reg         resend_reg;
    wire [2:0]  div_max;
    wire        wr_stb;
    wire        eod_clear;

    // register map, byte addresses on the bus
    //   0x0  control one
    //   0x4  control two
    //   0x8  status, read only
    //   0xc  state vector, read clears
    //
    // control one fields
    //   bit 6    timebase frequency select
    //   bits 5:4 rate select, one write per reset
    //   bit 1    interrupt request enable
    //   bit 0    wait clock stop
    //   others   read as zero
    //
    // control two fields
    //   bit 7    analog loopback
    //   bit 6    digital loopback
    //   bit 5    fast receive only
    //   bit 4    normalization bit format
    //   bit 3    end of data request
    //   bit 2    single byte response
    //   bit 1    multi byte response, crc
    //   bit 0    multi byte response, no crc
    //
    // status fields
    //   bit 2    interrupt pending
    //   bit 1    transmit buffer empty
    //   bit 0    rate bits locked
    //
    // bus timing
    //   a request is answered one cycle
    //   after it is first seen; writes land
    //   and read data stands in the ack cycle
    //   ack never stays high two cycles, but
    //   a held request is taken again every other cycle
    //
    // timebase
    //   the divider emits a one-cycle enable
    //   pulse; the link core counts symbol
    //   times in those pulses, never in raw
    //   system clocks
    //   divide by 4 or 8 still works here so
    //   that a misprogrammed part fails
    //   visibly rather than silently
    //
    // loopback exit
    //   both loopbacks share one idle counter;
    //   rx opens at the end-of-frame count
    //   and tx at the separator count
    //   any high level on the synced pin
    //   restarts the count from zero
    //   coming out of reset both loopbacks are
    //   set, so a fresh part also waits for
    //   idle before it joins the bus
    //
    // responses
    //   only the highest priority request bit
    //   drives the link core; the register
    //   keeps the pattern software wrote
    //   a multi byte responder that loses
    //   arbitration gives up; a single byte
    //   responder retries until its own byte
    //   is seen or the bus reports an error
    //

    // priority encode the response request bits
    function [2:0] ifr_encode;
        input [2:0] req;
        begin
            if (req[2])
                ifr_encode = 3'h4;
            else if (req[1])
                ifr_encode = 3'h2;
            else if (req[0])
                ifr_encode = 3'h1;
            else
                ifr_encode = 3'h0;
        end
    endfunction

    assign wr_stb    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
    // divide-by-4/8 remain implementable though unsupported on this part
    assign div_max   = (3'h1 << ctrl_one_reg[5:4]) - 3'h1;
    assign eod_clear = crc_bit_start_i | eod_rx_valid_i | bus_error_i;

    // two-flop sync for the receive pin
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_meta_reg <= 1'b0;
            rx_sync_reg <= 1'b0;
        end else begin
            rx_meta_reg <= digital_rx_in_i;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    // bus answer: one wait-free cycle, ack then drop
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            case (wb_adr_i)
                `ADDR_CTRL_ONE: wb_dat_o <= {24'h000000, ctrl_one_reg};
                `ADDR_CTRL_TWO: wb_dat_o <= {24'h000000, ctrl_two_reg};
                `ADDR_STATUS:   wb_dat_o <= {29'h00000000, irq_pend_reg,
                                             tx_empty_reg, rate_locked_reg};
                `ADDR_VECTOR:   wb_dat_o <= {16'h0000, vector_reg};
                default:        wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // control register one
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_one_reg    <= `CTRL_ONE_RESET;
            rate_locked_reg <= 1'b0;
        end else if (wr_stb && wb_adr_i == `ADDR_CTRL_ONE) begin
            ctrl_one_reg[7:6] <= {1'b0, wb_dat_i[`C1_FREQ_BIT]};
            ctrl_one_reg[3:0] <= {2'h0, wb_dat_i[1:0]};
            if (!rate_locked_reg) begin
                ctrl_one_reg[5:4] <= wb_dat_i[5:4];
                rate_locked_reg   <= 1'b1;
            end
        end
    end

    // control register two, with hardware clears
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_two_reg <= `CTRL_TWO_RESET;
        end else begin
            if (wr_stb && wb_adr_i == `ADDR_CTRL_TWO)
                ctrl_two_reg <= wb_dat_i[7:0];       // read as written
            if (break_rx_i)
                ctrl_two_reg[`C2_FAST_RX_BIT] <= 1'b0;
            // a hardware clear beats a same-cycle software set here,
            // since the clearing event already ended the transfer
            if (eod_clear)
                ctrl_two_reg[`C2_EOD_BIT] <= 1'b0;
            if (bus_error_i)
                ctrl_two_reg[2:0] <= 3'h0;
            else if (ifr_lost_i)
                ctrl_two_reg[1:0] <= 2'h0;   // multi byte responses give up
            if (own_byte_seen_i)
                ctrl_two_reg[`C2_SINGLE_BIT] <= 1'b0;
        end
    end

    // state vector and transmit-empty flag
    always @(posedge clk_i) begin
        if (rst_i) begin
            vector_reg   <= `VECTOR_IDLE;
            tx_empty_reg <= 1'b0;
        end else begin
            if (wr_stb && wb_adr_i == `ADDR_CTRL_TWO &&
                wb_dat_i[`C2_EOD_BIT])
                tx_empty_reg <= 1'b0;
            if (tx_empty_set_i)
                tx_empty_reg <= 1'b1;           // set wins over clear
            if (break_rx_i)
                vector_reg <= `VECTOR_BREAK;
            else if (tx_empty_reg && !(wr_stb &&
                     wb_adr_i == `ADDR_CTRL_TWO && wb_dat_i[`C2_EOD_BIT]))
                vector_reg <= `VECTOR_TX_EMPTY;
            else if (wb_cyc_i && wb_stb_i && !wb_we_i && wb_ack_o &&
                     wb_adr_i == `ADDR_VECTOR)
                vector_reg <= `VECTOR_IDLE;     // read clears the source
        end
    end

    // interrupt: held until sources clear, dropped if enable clears
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_pend_reg <= 1'b0;
            irq_o        <= 1'b0;
        end else begin
            if (irq_src_i || vector_reg != `VECTOR_IDLE)
                irq_pend_reg <= 1'b1;
            else
                irq_pend_reg <= 1'b0;
            if (!ctrl_one_reg[`C1_IRQ_EN_BIT] && !irq_src_i)
                irq_pend_reg <= 1'b0;
            irq_o <= (ctrl_one_reg[`C1_IRQ_EN_BIT] & irq_pend_reg
                      & ~cpu_wait_i) | wake_req_i;
        end
    end

    // timebase divider and wait-mode clock gating
    always @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt_reg     <= 3'h0;
            link_timebase_o <= 1'b0;
            core_clk_en_o   <= 1'b0;
        end else begin
            core_clk_en_o <= ~(cpu_wait_i &
                               ctrl_one_reg[`C1_WAIT_STOP_BIT]);
            if (cpu_wait_i && ctrl_one_reg[`C1_WAIT_STOP_BIT]) begin
                link_timebase_o <= 1'b0;
            end else if (div_cnt_reg >= div_max) begin
                div_cnt_reg     <= 3'h0;
                link_timebase_o <= 1'b1;
            end else begin
                div_cnt_reg     <= div_cnt_reg + 3'h1;
                link_timebase_o <= 1'b0;
            end
        end
    end

    // idle qualification after leaving either loopback
    always @(posedge clk_i) begin
        if (rst_i) begin
            idle_cnt_reg  <= 14'h0000;
            idle_wait_reg <= 1'b0;
        end else if (ctrl_two_reg[`C2_ANALOG_LOOPBACK_BIT] ||
                     ctrl_two_reg[`C2_DIGITAL_LOOPBACK_BIT]) begin
            idle_cnt_reg  <= 14'h0000;
            idle_wait_reg <= 1'b1;
        end else if (idle_wait_reg) begin
            // any bus activity restarts the idle measurement
            if (rx_sync_reg)
                idle_cnt_reg <= 14'h0000;
            else if (idle_cnt_reg < `IFS_COUNT)
                idle_cnt_reg <= idle_cnt_reg + 14'h0001;
            else
                idle_wait_reg <= 1'b0;
        end
    end

    // allow windows and loopback routing
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_allow_o       <= 1'b0;
            tx_allow_o       <= 1'b0;
            digital_tx_out_o <= 1'b0;
            link_rx_o        <= 1'b0;
        end else begin
            rx_allow_o <= ~idle_wait_reg |
                          (idle_cnt_reg >= `EOF_COUNT);
            tx_allow_o <= ~idle_wait_reg & ~fast_rx_mode_o;
            // digital loopback: core transmit feeds receive internally, so the bus line
            // itself must stay passive from this side
            digital_tx_out_o <= core_tx_i & ~ctrl_two_reg[`C2_DIGITAL_LOOPBACK_BIT];
            if (ctrl_two_reg[`C2_DIGITAL_LOOPBACK_BIT])
                link_rx_o <= core_tx_i;
            else
                link_rx_o <= rx_sync_reg;
        end
    end

    // mode, normalization and response outputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            timebase_binary_o  <= 1'b0;
            fast_rx_mode_o     <= 1'b0;
            norm_bit_crc_o     <= 1'b1;
            norm_bit_nocrc_o   <= 1'b0;
            crc_after_shadow_o <= 1'b0;
            send_single_o      <= 1'b0;
            send_multi_crc_o   <= 1'b0;
            send_multi_nocrc_o <= 1'b0;
            resend_reg         <= 1'b0;
            resend_id_o        <= 1'b0;
            send_norm_bit_o    <= 1'b0;
        end else begin
            timebase_binary_o <= ctrl_one_reg[`C1_FREQ_BIT];
            fast_rx_mode_o    <= ctrl_two_reg[`C2_FAST_RX_BIT];
            norm_bit_crc_o    <= ~ctrl_two_reg[`C2_NBF_BIT];
            norm_bit_nocrc_o  <= ctrl_two_reg[`C2_NBF_BIT];
            crc_after_shadow_o <= ctrl_two_reg[`C2_EOD_BIT] &
                                  shadow_full_i;
            {send_single_o, send_multi_crc_o, send_multi_nocrc_o} <=
                ifr_encode(ctrl_two_reg[2:0]);
            // single-byte responder retries its id after losing
            if (ifr_lost_i && ctrl_two_reg[`C2_SINGLE_BIT])
                resend_reg <= 1'b1;
            else if (own_byte_seen_i || bus_error_i ||
                     !ctrl_two_reg[`C2_SINGLE_BIT])
                resend_reg <= 1'b0;
            resend_id_o <= resend_reg;
            // one nb per response, never on a retry
            send_norm_bit_o <= eod_rx_valid_i & ~resend_reg &
                               (|ctrl_two_reg[2:0]);
        end
    end

endmodule // vpw_link_control_regs

/* tb/vpw_link_control_regs_asserts.sv */
// assertion checker for the vpw link control block ports
`timescale 1ns/1ps
module vpw_link_checks (
    input logic clk_i,
    input logic rst_i,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_ack_o,
    input logic core_tx_i,
    input logic digital_tx_out_o,
    input logic send_single_o,
    input logic send_multi_crc_o,
    input logic send_multi_nocrc_o,
    input logic norm_bit_crc_o,
    input logic norm_bit_nocrc_o,
    input logic break_rx_i,
    input logic fast_rx_mode_o,
    input logic ifr_lost_i,
    input logic own_byte_seen_i,
    input logic resend_id_o,
    input logic send_norm_bit_o,
    input logic wake_req_i,
    input logic irq_o,
    input logic rx_allow_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack stayed high for two cycles");
    a_ack_after_req: assert property
        (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in the next cycle");
    a_tx_from_core: assert property
        (digital_tx_out_o |-> $past(core_tx_i))
        else $error("transmit pin high without core transmit");
    a_resp_onehot: assert property
        ($onehot0({send_single_o, send_multi_crc_o, send_multi_nocrc_o}))
        else $error("more than one response type active");
    a_nb_levels_differ: assert property
        (norm_bit_crc_o != norm_bit_nocrc_o)
        else $error("crc and non-crc normalization levels equal");
    a_break_clears_fast: assert property
        (break_rx_i |-> ##[1:2] !fast_rx_mode_o)
        else $error("fast receive survived a break");
    a_lost_resends_id: assert property
        (ifr_lost_i && send_single_o && !own_byte_seen_i
         |-> ##[1:2] resend_id_o)
        else $error("lost responder did not resend its id");
    a_own_byte_stops: assert property
        (own_byte_seen_i && !ifr_lost_i |-> ##[1:2] !resend_id_o)
        else $error("id resend kept after own byte seen");
    a_single_nb_pulse: assert property
        (send_norm_bit_o |=> !send_norm_bit_o)
        else $error("normalization bit requested twice in a row");
    a_wake_not_gated: assert property
        (wake_req_i |-> ##[1:2] irq_o)
        else $error("wake request did not reach the cpu");

    // main scenarios the bench is expected to reach
    c_ack: cover property (wb_cyc_i ##1 wb_ack_o);
    c_resend: cover property (ifr_lost_i ##[1:2] resend_id_o);
    c_single: cover property (send_single_o);
    c_rx_open: cover property ($rose(rx_allow_o));
endmodule // vpw_link_checks

/* tb/vpw_xcvr_model.sv */
// behavioural transceiver that echoes the transmit pin after a delay
`timescale 1ns/1ps
module vpw_xcvr_model #(
    parameter int DELAY = 2
) (
    input  wire logic clk_i,
    input  wire logic tx_i,
    output wire logic rx_o
);
    logic [7:0] pipe = 8'h00;

    // bus round trip; passive bus reads low, so an idle line echoes 0
    always @(posedge clk_i) begin
        pipe <= {pipe[6:0], tx_i};
    end
    assign rx_o = pipe[DELAY-1]; // larger DELAY models a slow transceiver
endmodule // vpw_xcvr_model

/* tb/vpw_link_control_regs_tb_top.sv */
// self-checking bench for the vpw link control register block
`timescale 1ns/1ps
`include "vpw_link_defines.vh"
module vpw_link_control_regs_tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic        wb_ack_o, rx_pin, tx_pin, link_rx_o, link_timebase_o;
    logic        binary_o, clk_en_o, irq_o, fast_o, rx_ok_o, tx_ok_o;
    logic        nb_crc_o, nb_nocrc_o, after_shadow_o, resend_o, nb_o;
    logic [2:0]  resp_o;
    logic [6:0]  ev = 7'h00; // break,crc,eod,err,empty,lost,own
    logic [4:0]  lv = 5'h00; // wait,wake,irq,shadow,core_tx
    int          n_mismatch = 0, n_tests = 0, n;

    // 40 MHz system clock
    always #12.5 clk_i = ~clk_i;

    vpw_link_control_regs dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'h1), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_wait_i(lv[0]),
        .wake_req_i(lv[1]), .irq_src_i(lv[2]), .break_rx_i(ev[0]),
        .crc_bit_start_i(ev[1]), .eod_rx_valid_i(ev[2]),
        .bus_error_i(ev[3]), .tx_empty_set_i(ev[4]), .shadow_full_i(lv[3]),
        .ifr_lost_i(ev[5]), .own_byte_seen_i(ev[6]), .core_tx_i(lv[4]),
        .digital_rx_in_i(rx_pin), .digital_tx_out_o(tx_pin),
        .link_rx_o(link_rx_o), .link_timebase_o(link_timebase_o),
        .timebase_binary_o(binary_o), .core_clk_en_o(clk_en_o),
        .irq_o(irq_o), .fast_rx_mode_o(fast_o), .rx_allow_o(rx_ok_o),
        .tx_allow_o(tx_ok_o), .norm_bit_crc_o(nb_crc_o),
        .norm_bit_nocrc_o(nb_nocrc_o), .crc_after_shadow_o(after_shadow_o),
        .send_single_o(resp_o[2]), .send_multi_crc_o(resp_o[1]),
        .send_multi_nocrc_o(resp_o[0]), .resend_id_o(resend_o),
        .send_norm_bit_o(nb_o));

    vpw_xcvr_model #(.DELAY(3)) xcvr (.clk_i(clk_i), .tx_i(tx_pin),
        .rx_o(rx_pin));

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one classic cycle; waits for ack, bounded so a dead slave ends
    task automatic wb(input logic we, input logic [3:0] a,
                      input logic [7:0] d);
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 50) n_mismatch++;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic pulse(input int b);
        @(posedge clk_i);
        ev[b] <= 1'b1;
        @(posedge clk_i);
        ev <= 7'h00;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic level(input int b, input logic v);
        @(posedge clk_i);
        lv[b] <= v;
        repeat (4) @(posedge clk_i);
    endtask

    task automatic count_tb(input logic [31:0] exp);
        n = 0;
        repeat (16) begin
            @(posedge clk_i);
            if (link_timebase_o === 1'b1) n++;
        end
        check("timebase pulses", n, exp);
    endtask

    // rate bits lock after the first write; only divide 1 or 2 is used
    task automatic t_ctrl_one;
        wb(0, `ADDR_CTRL_ONE, 8'h0);
        check("ctrl_one reset", q[7:0], 8'h00);
        count_tb(16);
        wb(1, `ADDR_CTRL_ONE, 8'h50);
        check("binary timebase", binary_o, 1'b1);
        count_tb(8);
        wb(1, `ADDR_CTRL_ONE, 8'h02);
        wb(0, `ADDR_CTRL_ONE, 8'h0);
        check("rate locked", q[7:0], 8'h12);
        check("integer timebase", binary_o, 1'b0);
        count_tb(8);
        level(2, 1'b1);
        check("irq enabled", irq_o, 1'b1);
        repeat (20) @(posedge clk_i);
        check("irq held", irq_o, 1'b1);
        level(2, 1'b0);
        check("irq released", irq_o, 1'b0);
        wb(1, `ADDR_CTRL_ONE, 8'h00);
        level(2, 1'b1);
        check("irq gated", irq_o, 1'b0);
        level(2, 1'b0);
        level(1, 1'b1);
        check("wake ungated", irq_o, 1'b1);
        level(1, 1'b0);
        level(0, 1'b1);
        check("clocks run", clk_en_o, 1'b1);
        wb(1, `ADDR_CTRL_ONE, 8'h01);
        check("clocks stopped", clk_en_o, 1'b0);
        level(0, 1'b0);
        wb(1, `ADDR_CTRL_ONE, 8'h00);
    endtask

    // loopbacks at reset, then the idle waits after they are cleared
    task automatic t_loop;
        wb(0, `ADDR_CTRL_TWO, 8'h0);
        check("ctrl_two reset", q[7:0], 8'hc0);
        wb(0, 4'h2, 8'h0);
        check("unmapped read", q, 32'h0);
        level(4, 1'b1);
        check("loop rx", link_rx_o, 1'b1);
        check("bus undriven", tx_pin, 1'b0);
        level(4, 1'b0);
        wb(1, `ADDR_CTRL_TWO, 8'h00);
        repeat (11000) @(posedge clk_i);
        check("rx held off", rx_ok_o, 1'b0);
        repeat (400) @(posedge clk_i);
        check("rx allowed", rx_ok_o, 1'b1);
        repeat (500) @(posedge clk_i);
        check("tx held off", tx_ok_o, 1'b0);
        repeat (300) @(posedge clk_i);
        check("tx allowed", tx_ok_o, 1'b1);
        level(4, 1'b1);
        check("bus driven", tx_pin, 1'b1);
        // echo needs transceiver delay plus the two sync flops
        repeat (4) @(posedge clk_i);
        check("rx from pin", link_rx_o, 1'b1);
        level(4, 1'b0);
    endtask

    // every response pattern, priority encoded but read back as written
    task automatic t_resp;
        logic [2:0] e;
        for (int v = 7; v >= 0; v--) begin
            e = v[2] ? 3'b100 : v[1] ? 3'b010 : v[0] ? 3'b001 : 3'b000;
            wb(1, `ADDR_CTRL_TWO, {5'h0, v[2:0]});
            wb(0, `ADDR_CTRL_TWO, 8'h0);
            check("resp readback", q[7:0], {5'h0, v[2:0]});
            check("resp actual", resp_o, e);
        end
        wb(1, `ADDR_CTRL_TWO, 8'h04);
        @(posedge clk_i);
        ev[2] <= 1'b1;
        @(posedge clk_i);
        ev <= 7'h00;
        @(posedge clk_i);
        check("nb sent", nb_o, 1'b1);
        repeat (2) @(posedge clk_i);
        wb(0, `ADDR_CTRL_TWO, 8'h0);
        pulse(5);
        check("resend id", resend_o, 1'b1);
        pulse(6);
        check("resend done", resend_o, 1'b0);
        wb(1, `ADDR_CTRL_TWO, 8'h10);
        check("nb crc", {nb_crc_o, nb_nocrc_o}, 2'b01);
        wb(1, `ADDR_CTRL_TWO, 8'h00);
        check("nb swapped", {nb_crc_o, nb_nocrc_o}, 2'b10);
    endtask

    // fast receive, break, end of data and its automatic clears
    task automatic t_misc;
        wb(1, `ADDR_CTRL_TWO, 8'h20);
        check("fast rx", fast_o, 1'b1);
        pulse(0);
        check("fast cleared", fast_o, 1'b0);
        wb(0, `ADDR_VECTOR, 8'h0);
        check("break vector", q[15:0], `VECTOR_BREAK);
        pulse(4);
        wb(0, `ADDR_STATUS, 8'h0);
        check("tx empty", q[1], 1'b1);
        level(3, 1'b1);
        wb(1, `ADDR_CTRL_TWO, 8'h08);
        check("crc after shadow", after_shadow_o, 1'b1);
        wb(0, `ADDR_STATUS, 8'h0);
        check("empty cleared", q[1], 1'b0);
        pulse(1);
        wb(0, `ADDR_CTRL_TWO, 8'h0);
        check("eod crc clear", q[3], 1'b0);
        wb(1, `ADDR_CTRL_TWO, 8'h08);
        pulse(3);
        wb(0, `ADDR_CTRL_TWO, 8'h0);
        check("eod error clear", q[3], 1'b0);
        level(3, 1'b0);
    endtask

    task automatic close_out;
        if (n_mismatch == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // main sequence after a 12 cycle reset
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        check("nb at reset", nb_crc_o, 1'b1);
        t_ctrl_one;
        t_loop;
        t_resp;
        t_misc;
        close_out;
    end

    // watchdog well beyond the roughly 12600 cycles the run needs
    initial begin
        repeat (40000) @(posedge clk_i);
        n_mismatch++;
        close_out;
    end
endmodule // vpw_link_control_regs_tb_top

bind vpw_link_control_regs vpw_link_checks u_chk (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .core_tx_i(core_tx_i),
    .digital_tx_out_o(digital_tx_out_o), .send_single_o(send_single_o),
    .send_multi_crc_o(send_multi_crc_o),
    .send_multi_nocrc_o(send_multi_nocrc_o),
    .norm_bit_crc_o(norm_bit_crc_o), .norm_bit_nocrc_o(norm_bit_nocrc_o),
    .break_rx_i(break_rx_i), .fast_rx_mode_o(fast_rx_mode_o),
    .ifr_lost_i(ifr_lost_i), .own_byte_seen_i(own_byte_seen_i),
    .resend_id_o(resend_id_o), .send_norm_bit_o(send_norm_bit_o),
    .wake_req_i(wake_req_i), .irq_o(irq_o), .rx_allow_o(rx_allow_o));
